// file: tpi_consts.vh
// Purpose: Constants for the transmit payload input block
// Assumes: 10 MHz system clock, payload clocks sampled as plain inputs
// Notes:   Frame lengths are defaults; shorten them in simulation
`ifndef TPI_CONSTS_VH
`define TPI_CONSTS_VH

`define TPI_MODE_SERIAL     2'h0
`define TPI_MODE_NIBBLE     2'h1
`define TPI_MODE_HDLC       2'h2
`define TPI_NIB_W           4
`define TPI_FIFO_DEPTH      4
`define TPI_FIFO_AW         2
`define TPI_DS3_FRAME_BITS  16'h1260
`define TPI_E3_FRAME_BITS   16'h0F00
`define TPI_CNT_W           16
`define TPI_ONE16           16'h0001
`define TPI_ZERO16          16'h0000
`define TPI_BIT_HDLC1       1
`define TPI_BIT_HDLC2       2
`define TPI_PINS            8
`define TPI_PIN_NCLK        7
`define TPI_PIN_LCLK        6
`define TPI_PIN_RCLK        5
`define TPI_PIN_SER         4
`define TPI_PIN_NIB_HI      3
`define TPI_PIN_NIB_LO      0
`define TPI_WORD_W          5
`define TPI_WORD_FLAG       4
`define TPI_SER_BIT         0
`define TPI_NIB_LAST        2'h3
`define TPI_IDX_ZERO        2'h0
`define TPI_IDX_ONE         2'h1

`endif

// file: tpi_fifo.v
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-high reset
// Notes:   Read data comes from a register
`timescale 1ns/100ps
module tpi_fifo #(
    parameter WIDTH = 5,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    wire            can_load;

    // Output register counts as one extra slot filled by pop
    assign can_load = (cnt_q != {(AW+1){1'b0}}) && (!out_valid || out_ready);
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign push     = in_valid && in_ready;
    assign pop      = can_load;

    always @(posedge clk) begin
        if (rst) begin
            wr_q      <= {AW{1'b0}};
            rd_q      <= {AW{1'b0}};
            cnt_q     <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q        <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                out_data <= mem_q[rd_q];
                rd_q     <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop)
                out_valid <= 1'b1;
            else if (out_ready)
                out_valid <= 1'b0;
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// file: tpi_payload_in.v
// Purpose: Transmit payload input interface of one framer channel
// Assumes: Payload clocks and data are asynchronous pins, synchronised here
// Notes:   Framer side drains a 4-entry FIFO one bit per frame slot
`timescale 1ns/100ps
`include "tpi_consts.vh"

// Behaviour
// - The frame-end pulse is high for exactly one bit period on the last bit of each frame.
// - In nibble mode the four nibble lines are captured on each rising nibble clock edge.
// - Nibble inputs are used as payload only in nibble mode and ignored otherwise, except lines 1 and 2 in HDLC mode.
// - With HDLC enabled the second nibble line is bit 1 of the HDLC data byte.
// - With HDLC enabled the third nibble line is bit 2 of the HDLC data byte.
// - Serial data is sampled on the rising local clock, or recovered clock in loop timing.
module tpi_payload_in (
    input  wire       clk,
    input  wire       rst,
    input  wire [1:0] mode_sel,
    input  wire       loop_timed,
    input  wire       e3_select,
    input  wire       tx_nibble_sample_clock,
    input  wire       tx_local_clock_in,
    input  wire       rx_recovered_clock_out,
    input  wire       tx_serial_payload_in,
    input  wire       tx_payload_nibble_bit0,
    input  wire       tx_payload_nibble_bit1,
    input  wire       tx_payload_nibble_bit2,
    input  wire       tx_payload_nibble_bit3,
    input  wire       frame_bit_ready,
    output reg        tx_frame_end_pulse,
    output reg        payload_bit,
    output reg        payload_bit_valid,
    output reg        tx_msg_byte_bit1,
    output reg        tx_msg_byte_bit2,
    output reg        send_message_q,
    output reg        fifo_full_q
);
    // Three flops per pin; the third stage only feeds edge detection
    wire [`TPI_PINS-1:0] pin_raw;
    reg  [`TPI_PINS-1:0] sync1_q;
    reg  [`TPI_PINS-1:0] sync2_q;
    reg  [`TPI_PINS-1:0] sync3_q;
    assign pin_raw = {tx_nibble_sample_clock, tx_local_clock_in, rx_recovered_clock_out,
                      tx_serial_payload_in, tx_payload_nibble_bit3, tx_payload_nibble_bit2,
                      tx_payload_nibble_bit1, tx_payload_nibble_bit0};
    genvar gi;
    generate
        for (gi = 0; gi < `TPI_PINS; gi = gi + 1) begin : g_sync
            always @(posedge clk) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    // Pin clocks are oversampled, so each level must last more than one clk cycle
    wire                  nib_clk_rise;
    wire                  loc_clk_rise;
    wire                  rec_clk_rise;
    wire                  ser_clk_rise;
    wire                  ser_data;
    wire [`TPI_NIB_W-1:0] nib_data;
    wire                  is_nibble;
    wire                  is_serial;
    wire                  is_hdlc;

    assign nib_clk_rise = sync2_q[`TPI_PIN_NCLK] && !sync3_q[`TPI_PIN_NCLK];
    assign loc_clk_rise = sync2_q[`TPI_PIN_LCLK] && !sync3_q[`TPI_PIN_LCLK];
    assign rec_clk_rise = sync2_q[`TPI_PIN_RCLK] && !sync3_q[`TPI_PIN_RCLK];
    assign ser_clk_rise = loop_timed ? rec_clk_rise : loc_clk_rise;
    assign ser_data     = sync2_q[`TPI_PIN_SER];
    assign nib_data     = sync2_q[`TPI_PIN_NIB_HI:`TPI_PIN_NIB_LO];
    assign is_nibble    = (mode_sel == `TPI_MODE_NIBBLE);
    assign is_serial    = (mode_sel == `TPI_MODE_SERIAL);
    assign is_hdlc      = (mode_sel == `TPI_MODE_HDLC);

    // Capture side: flag bit marks a nibble word, else one serial bit
    reg  [`TPI_WORD_W-1:0] in_word;
    reg                    in_valid;
    wire                   in_ready;
    always @* begin
        in_word  = {`TPI_WORD_W{1'b0}};
        in_valid = 1'b0;
        // Unused mode code captures nothing
        if (is_nibble && nib_clk_rise) begin
            in_word  = {1'b1, nib_data};
            in_valid = 1'b1;
        end else if (is_serial && ser_clk_rise) begin
            in_word  = {1'b0, {(`TPI_NIB_W-1){1'b0}}, ser_data};
            in_valid = 1'b1;
        end
    end

    wire [`TPI_WORD_W-1:0] out_word;
    wire                   out_valid;
    reg                    out_ready;

    // A capture arriving while full is dropped; the pins cannot be stalled
    tpi_fifo #(
        .WIDTH (`TPI_WORD_W),
        .DEPTH (`TPI_FIFO_DEPTH),
        .AW    (`TPI_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (in_word),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (out_word),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

    // Drain side: nibbles leave MSB first, one bit per framer slot
    reg  [1:0]            nib_idx_q;
    reg  [1:0]            nib_idx_d;
    reg  [`TPI_CNT_W-1:0] bit_cnt_q;
    reg  [`TPI_CNT_W-1:0] bit_cnt_d;
    reg  [`TPI_CNT_W-1:0] frame_last;
    reg                   payload_bit_d;
    reg                   frame_end_d;
    wire                  is_packed;
    wire                  last_of_word;
    wire                  at_frame_last;
    wire                  take_bit;

    always @* begin
        if (e3_select)
            frame_last = `TPI_E3_FRAME_BITS - `TPI_ONE16;
        else
            frame_last = `TPI_DS3_FRAME_BITS - `TPI_ONE16;
    end
    assign is_packed     = out_word[`TPI_WORD_FLAG];
    assign last_of_word  = !is_packed || (nib_idx_q == `TPI_NIB_LAST);
    assign at_frame_last = (bit_cnt_q == frame_last);
    // Framer may pull every cycle; a nibble then drains in four
    assign take_bit      = out_valid && frame_bit_ready;

    always @* begin
        nib_idx_d     = nib_idx_q;
        bit_cnt_d     = bit_cnt_q;
        payload_bit_d = payload_bit;
        frame_end_d   = 1'b0;
        out_ready     = 1'b0;
        if (take_bit) begin
            // Word leaves the FIFO only with its last bit
            out_ready   = last_of_word;
            frame_end_d = at_frame_last;
            if (is_packed)
                payload_bit_d = out_word[`TPI_NIB_LAST - nib_idx_q];
            else
                payload_bit_d = out_word[`TPI_SER_BIT];
            if (last_of_word)
                nib_idx_d = `TPI_IDX_ZERO;
            else
                nib_idx_d = nib_idx_q + `TPI_IDX_ONE;
            // Counter wraps by itself, so frames stay aligned with no restart
            if (at_frame_last)
                bit_cnt_d = `TPI_ZERO16;
            else
                bit_cnt_d = bit_cnt_q + `TPI_ONE16;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            nib_idx_q          <= `TPI_IDX_ZERO;
            bit_cnt_q          <= `TPI_ZERO16;
            tx_frame_end_pulse <= 1'b0;
            payload_bit        <= 1'b0;
            payload_bit_valid  <= 1'b0;
        end else begin
            nib_idx_q          <= nib_idx_d;
            bit_cnt_q          <= bit_cnt_d;
            // Pulse lasts one bit slot, the last of each frame
            tx_frame_end_pulse <= frame_end_d;
            payload_bit        <= payload_bit_d;
            payload_bit_valid  <= take_bit;
        end
    end

    // Message-mode lines are only resynchronised; packet framing is downstream
    reg                   msg_bit1_d;
    reg                   msg_bit2_d;
    reg                   send_msg_d;

    always @* begin
        msg_bit1_d = 1'b0;
        msg_bit2_d = 1'b0;
        send_msg_d = 1'b0;
        if (is_hdlc) begin
            msg_bit1_d = nib_data[`TPI_BIT_HDLC1];
            msg_bit2_d = nib_data[`TPI_BIT_HDLC2];
            // Packet framing relies on the terminal holding this level
            send_msg_d = ser_data;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            tx_msg_byte_bit1 <= 1'b0;
            tx_msg_byte_bit2 <= 1'b0;
            send_message_q   <= 1'b0;
            fifo_full_q      <= 1'b0;
        end else begin
            tx_msg_byte_bit1 <= msg_bit1_d;
            tx_msg_byte_bit2 <= msg_bit2_d;
            send_message_q   <= send_msg_d;
            // Flag is a cycle late; the capture that filled the FIFO still lands
            fifo_full_q      <= !in_ready;
        end
    end
endmodule

// file: tpi_checker.sv
// Purpose: Port checker for tpi_payload_in
// Assumes: Pins change on falling clk edges
// Notes:   Bounds allow for the 3-cycle pin sync
`timescale 1ns/100ps
`include "tpi_consts.vh"
module tpi_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [1:0] mode_sel,
    input wire logic       loop_timed,
    input wire logic       tx_nibble_sample_clock,
    input wire logic       tx_local_clock_in,
    input wire logic       rx_recovered_clock_out,
    input wire logic       tx_payload_nibble_bit1,
    input wire logic       tx_payload_nibble_bit2,
    input wire logic       frame_bit_ready,
    input wire logic       tx_frame_end_pulse,
    input wire logic       payload_bit_valid,
    input wire logic       tx_msg_byte_bit1,
    input wire logic       tx_msg_byte_bit2
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire hd = mode_sel == `TPI_MODE_HDLC;
    wire sr = mode_sel == `TPI_MODE_SERIAL && frame_bit_ready;
    end_pulse_single_a: assert property (
        tx_frame_end_pulse |-> payload_bit_valid ##1 !tx_frame_end_pulse)
        else $error("frame end pulse malformed");
    nibble_capture_a: assert property (
        mode_sel == `TPI_MODE_NIBBLE && frame_bit_ready && $rose(tx_nibble_sample_clock)
        |-> ##[2:8] payload_bit_valid) else $error("nibble not captured");
    hdlc_no_payload_a: assert property (
        (hd && frame_bit_ready) [*8] |-> !payload_bit_valid)
        else $error("payload delivered in message mode");
    hdlc_bit_one_a: assert property (
        (hd && $stable(tx_payload_nibble_bit1)) [*5] |-> tx_msg_byte_bit1 == tx_payload_nibble_bit1)
        else $error("message bit 1 wrong");
    hdlc_bit_two_a: assert property (
        (hd && $stable(tx_payload_nibble_bit2)) [*5] |-> tx_msg_byte_bit2 == tx_payload_nibble_bit2)
        else $error("message bit 2 wrong");
    serial_local_a: assert property (
        sr && !loop_timed && $rose(tx_local_clock_in) |-> ##[2:8] payload_bit_valid)
        else $error("local serial bit not sampled");
    serial_loop_a: assert property (
        sr && loop_timed && $rose(rx_recovered_clock_out) |-> ##[2:8] payload_bit_valid)
        else $error("loop serial bit not sampled");
    cover property (tx_frame_end_pulse);
    cover property (payload_bit_valid && loop_timed);
    cover property (hd && tx_msg_byte_bit1);
endmodule

// file: tpi_terminal.sv
// Purpose: Terminal equipment driving the payload pins
// Assumes: Pin clocks high and low 4 clk cycles each
// Notes:   Data flips after each falling pin clock edge, so stale data never matches
`timescale 1ns/100ps
`include "tpi_consts.vh"
module tpi_terminal (
    input  wire logic       clk,
    output logic            nclk,
    output logic            lclk,
    output logic            rclk,
    output logic            ser,
    output logic      [3:0] nib
);
    initial {nclk, lclk, rclk, ser, nib} = 8'h00;
    task automatic send(input logic [1:0] m, input logic lp, input logic [3:0] w);
        {ser, nib} = {w[0], w};
        repeat (4) @(negedge clk);
        nclk = m == `TPI_MODE_NIBBLE;
        rclk = m != `TPI_MODE_NIBBLE && lp;
        lclk = m != `TPI_MODE_NIBBLE && !lp;
        repeat (4) @(negedge clk);
        {nclk, lclk, rclk} = 3'h0;
        {ser, nib} = ~{w[0], w};
    endtask
    task automatic hold(input logic b1, input logic b2, input logic msg);
        {ser, nib[2:1]} = {msg, b2, b1};
    endtask
endmodule

// file: tb.sv
// Purpose: Self-checking bench for tpi_payload_in
// Assumes: Inputs driven on falling clk edges
// Notes:   Full frames are sent, so the run is long
`timescale 1ns/100ps
`include "tpi_consts.vh"
module tb;
    typedef struct packed {logic [1:0] m; logic lp; logic [3:0] w;} tpi_row_t;
    logic       clk = 1'h0;
    logic       rst = 1'h1;
    logic [1:0] mode_sel = 2'h0;
    logic       loop_timed = 1'h0;
    logic       e3_select = 1'h0;
    logic       frame_bit_ready = 1'h1;
    wire        nclk, lclk, rclk, ser, pend, pbit, pval, mb1, mb2, smsg, full;
    wire  [3:0] nib;
    int         err_total = 0, samples_checked = 0, cycles = 0, nbits = 0, end_at = 0, n;
    logic       got[$];
    tpi_row_t   rows[6] = '{'{0, 0, 1}, '{0, 0, 0}, '{0, 1, 1}, '{0, 1, 0}, '{1, 0, 10}, '{1, 0, 5}};
    always #50 clk = ~clk;
    tpi_terminal term (.clk(clk), .nclk(nclk), .lclk(lclk), .rclk(rclk), .ser(ser), .nib(nib));
    tpi_payload_in uut (.clk(clk), .rst(rst), .mode_sel(mode_sel), .loop_timed(loop_timed),
        .e3_select(e3_select), .tx_nibble_sample_clock(nclk), .tx_local_clock_in(lclk),
        .rx_recovered_clock_out(rclk), .tx_serial_payload_in(ser),
        .tx_payload_nibble_bit0(nib[0]), .tx_payload_nibble_bit1(nib[1]),
        .tx_payload_nibble_bit2(nib[2]), .tx_payload_nibble_bit3(nib[3]),
        .frame_bit_ready(frame_bit_ready), .tx_frame_end_pulse(pend), .payload_bit(pbit),
        .payload_bit_valid(pval), .tx_msg_byte_bit1(mb1), .tx_msg_byte_bit2(mb2),
        .send_message_q(smsg), .fifo_full_q(full));
    task final_report;
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0h seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task rst_dut;
        rst = 1'h1;
        repeat (4) @(negedge clk);
        rst = 1'h0;
        nbits = 0;
        end_at = 0;
    endtask
    always @(negedge clk) begin
        cycles++;
        if (pval === 1'h1) begin
            got.push_back(pbit);
            nbits++;
        end
        if (pend === 1'h1) end_at = nbits;
        if (cycles == 60000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        rst_dut();
        check({pend, pval, mb1, mb2, smsg, full}, 16'h0000);
        foreach (rows[i]) begin
            {mode_sel, loop_timed} = {rows[i].m, rows[i].lp};
            got.delete();
            term.send(rows[i].m, rows[i].lp, rows[i].w);
            repeat (8) @(negedge clk);
            n = rows[i].m == `TPI_MODE_NIBBLE ? 4 : 1;
            check(16'(got.size()), 16'(n));
            for (int j = 0; j < n; j++) check(got[j], rows[i].w[n - 1 - j]);
        end
        // Back-pressure: four queued plus one held, sixth bit lost
        {mode_sel, loop_timed, frame_bit_ready} = 4'h0;
        got.delete();
        for (int j = 0; j < 6; j++) term.send(0, 0, 4'(6'h2D >> j));
        check(full, 16'h0001);
        frame_bit_ready = 1'h1;
        repeat (12) @(negedge clk);
        check(16'(got.size()), 16'h0005);
        for (int j = 0; j < 5; j++) check(got[j], 16'((6'h2D >> j) & 6'h01));
        // Nibble clock ignored in serial and HDLC modes
        for (int k = 0; k < 3; k = k + 2) begin
            mode_sel = 2'(k);
            got.delete();
            term.send(`TPI_MODE_NIBBLE, 0, 4'hF);
            repeat (8) @(negedge clk);
            check(16'(got.size()), 16'h0000);
        end
        term.hold(1, 0, 1);
        repeat (8) @(negedge clk);
        check({mb2, mb1, smsg}, 16'h0003);
        term.hold(0, 1, 0);
        repeat (8) @(negedge clk);
        check({mb2, mb1, smsg}, 16'h0004);
        // Two whole frames each; the second starts after the end pulse
        for (int f = 0; f < 2; f++) begin
            mode_sel = `TPI_MODE_NIBBLE;
            e3_select = f == 0;
            rst_dut();
            check({pend, pval, pbit, mb1, mb2, smsg, full}, 16'h0000);
            n = f == 0 ? `TPI_E3_FRAME_BITS : `TPI_DS3_FRAME_BITS;
            for (int r = 1; r < 3; r++) begin
                repeat (n / 4) term.send(`TPI_MODE_NIBBLE, 0, 4'h9);
                repeat (8) @(negedge clk);
                check(16'(end_at), 16'(n * r));
            end
        end
        final_report;
    end
endmodule
bind tpi_payload_in tpi_checker chk (.clk, .rst, .mode_sel, .loop_timed,
    .tx_nibble_sample_clock, .tx_local_clock_in, .rx_recovered_clock_out,
    .tx_payload_nibble_bit1, .tx_payload_nibble_bit2, .frame_bit_ready,
    .tx_frame_end_pulse, .payload_bit_valid, .tx_msg_byte_bit1, .tx_msg_byte_bit2);
